/* hdl/ebc_cs_decode.sv */
// Purpose: Address window match for one chip select
// Assumes: Base bits 11:8 read as zero
// Notes: Reserved size codes never match
`timescale 1ns/1ps
module ebc_cs_decode (
  ebc_win_if.decoder win
);
  logic [23:8] mask;
  logic [23:8] base_full;

  assign base_full = {win.base, 4'h0};

  always_comb begin
    for (int i = 8; i <= 23; i++) begin
      mask[i] = (i - ebc_pkg::SIZE_MIN_LOG2) >= int'(win.size_code);
    end
  end

  assign win.hit = (win.mode != ebc_pkg::EBC_MODE_OFF) &&
                   (win.size_code <= ebc_pkg::SIZE_FULL) &&
                   (((win.addr[23:8] ^ base_full) & mask) == 16'h0000);
endmodule

/* hdl/ebc_delay_cnt.sv */
// Purpose: Loadable down counter for command spacing
// Assumes: Load value is a cycle count
// Notes: zero is high once the loaded count has elapsed
`timescale 1ns/1ps
module ebc_delay_cnt #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire logic [W-1:0] value,
  // Status
  output logic zero
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= value;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign zero = (cnt_reg == '0);
endmodule

/* hdl/ebc_pkg.sv */
// Purpose: Constants for the chip select and SDRAM timing block
// Assumes: One clock, the doubled peripheral clock, 10 MHz
// Notes: Register byte address is four times its index
package ebc_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int NUM_CS = 4;
  localparam int SDRAM_CS = 3;
  // Register indices
  localparam logic [5:0] IDX_TIMING = 6'h09;
  localparam logic [5:0] IDX_CS0 = 6'h10;
  localparam logic [1:0] SUB_SIZE_TYPE = 2'h0;
  localparam logic [1:0] SUB_SRAM_WAIT = 2'h1;
  localparam logic [1:0] SUB_BASE = 2'h2;
  localparam logic [5:0] IDX_STATUS = 6'h20;
  // Field positions
  localparam int WR_LSB = 6;
  localparam int ESR_LSB = 3;
  localparam int RCD_LSB = 0;
  localparam int SIZE_LSB = 2;
  localparam int MODE_LSB = 0;
  localparam int BASE_LSB = 4;
  localparam int SRREQ_BIT = 2;
  // Reset values
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [4:0] SIZE_RST = 5'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [2:0] SRAM_WAIT_RST = 3'h0;
  localparam logic [11:0] BASE_RST = 12'h000;
  // Size codes
  localparam logic [4:0] SIZE_FULL = 5'h10;
  localparam int SIZE_MIN_LOG2 = 8;
  typedef enum logic [1:0] {
    EBC_MODE_OFF = 2'b00,
    EBC_MODE_SRAM = 2'b01,
    EBC_MODE_LOW_PIN_COUNT_SRAM = 2'b10,
    EBC_MODE_SDRAM = 2'b11
  } ebc_mode_t;
  typedef enum logic [2:0] {
    EBC_CMD_NOP = 3'b000,
    EBC_CMD_ACTIVE = 3'b001,
    EBC_CMD_READ = 3'b010,
    EBC_CMD_WRITE = 3'b011,
    EBC_CMD_SELF_REFRESH = 3'b100
  } ebc_cmd_t;
endpackage

/* hdl/ebc_top.sv */
// Purpose: Chip select windows, SRAM wait states and SDRAM timing
// Assumes: Classic Wishbone slave, memory requester on the same clock
// Notes: One access at a time; requester holds mem_req until mem_ack
`timescale 1ns/1ps
module ebc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Memory access requests
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  output logic mem_ack,
  output logic mem_err,
  // External memory side
  output logic [3:0] cs_n,
  output logic [2:0] sd_cmd,
  output logic sd_cke
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SRAM = 3'b001,
    ST_RCD = 3'b010,
    ST_WREC = 3'b011,
    ST_SELF = 3'b100,
    ST_EXIT = 3'b101
  } ebc_state_t;

  ebc_state_t state_reg;
  logic [7:0] timing_reg;
  logic [4:0] size_reg [ebc_pkg::NUM_CS];
  logic [1:0] mode_reg [ebc_pkg::NUM_CS];
  logic [2:0] sram_wait_reg [ebc_pkg::NUM_CS];
  logic [11:0] base_reg [ebc_pkg::NUM_CS];
  logic [3:0] last_hit_reg;
  logic [3:0] hit;
  logic [5:0] idx;
  logic cs_area;
  logic [1:0] cs_num;
  logic [1:0] sub;
  logic wb_go;
  logic wb_wr;
  logic [31:0] rd_data;
  logic [1:0] wr_cyc;
  logic [2:0] esr_cyc;
  logic [2:0] rcd_cyc;
  logic sdram_on;
  logic sr_req;
  logic any_hit;
  logic [1:0] sel_cs;
  logic sel_sdram;
  logic cnt_load;
  logic [2:0] cnt_value;
  logic cnt_zero;

  // Window decoders, one per chip select
  for (genvar g = 0; g < ebc_pkg::NUM_CS; g++) begin : g_win
    ebc_win_if win ();
    assign win.size_code = size_reg[g];
    assign win.mode = mode_reg[g];
    assign win.base = base_reg[g];
    assign win.addr = mem_addr;
    assign hit[g] = win.hit;
    ebc_cs_decode i_ebc_cs_decode (
      .win(win.decoder)
    );
  end

  // Register decode
  assign idx = wb_adr_i[7:2];
  assign cs_area = (idx[5:4] == ebc_pkg::IDX_CS0[5:4]);
  assign cs_num = idx[3:2];
  assign sub = idx[1:0];
  assign wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_go && wb_we_i;

  assign wr_cyc = timing_reg[ebc_pkg::WR_LSB +: 2];
  assign esr_cyc = timing_reg[ebc_pkg::ESR_LSB +: 3];
  assign rcd_cyc = timing_reg[ebc_pkg::RCD_LSB +: 3];

  assign sdram_on = (mode_reg[ebc_pkg::SDRAM_CS] == ebc_pkg::EBC_MODE_SDRAM);
  assign sr_req = sdram_on && sram_wait_reg[ebc_pkg::SDRAM_CS][ebc_pkg::SRREQ_BIT];

  // Lowest numbered matching window wins on overlap
  always_comb begin
    any_hit = 1'b0;
    sel_cs = 2'h0;
    for (int i = ebc_pkg::NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        sel_cs = 2'(i);
      end
    end
  end
  assign sel_sdram = (mode_reg[sel_cs] == ebc_pkg::EBC_MODE_SDRAM);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_go;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timing_reg <= ebc_pkg::TIMING_RST;
    end else if (wb_wr && idx == ebc_pkg::IDX_TIMING && wb_sel_i[0]) begin
      timing_reg <= wb_dat_i[7:0];
    end
  end

  // Chip select configuration writes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < ebc_pkg::NUM_CS; i++) begin
        size_reg[i] <= ebc_pkg::SIZE_RST;
        mode_reg[i] <= ebc_pkg::MODE_RST;
        sram_wait_reg[i] <= ebc_pkg::SRAM_WAIT_RST;
        base_reg[i] <= ebc_pkg::BASE_RST;
      end
    end else if (wb_wr && cs_area) begin
      if (sub == ebc_pkg::SUB_SIZE_TYPE && wb_sel_i[0]) begin
        size_reg[cs_num] <= wb_dat_i[ebc_pkg::SIZE_LSB +: 5];
        if (wb_dat_i[1:0] == ebc_pkg::EBC_MODE_SDRAM && cs_num != 2'(ebc_pkg::SDRAM_CS)) begin
          mode_reg[cs_num] <= ebc_pkg::EBC_MODE_OFF;
        end else begin
          mode_reg[cs_num] <= wb_dat_i[ebc_pkg::MODE_LSB +: 2];
        end
      end
      // wait states, self-refresh request share bits 2:0
      if (sub == ebc_pkg::SUB_SRAM_WAIT && wb_sel_i[0]) begin
        sram_wait_reg[cs_num] <= wb_dat_i[2:0];
      end
      if (sub == ebc_pkg::SUB_BASE) begin
        if (wb_sel_i[0]) begin
          base_reg[cs_num][3:0] <= wb_dat_i[ebc_pkg::BASE_LSB +: 4];
        end
        if (wb_sel_i[1]) begin
          base_reg[cs_num][11:4] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (idx == ebc_pkg::IDX_TIMING) begin
      rd_data[7:0] = timing_reg;
    end else if (idx == ebc_pkg::IDX_STATUS) begin
      rd_data[0] = (state_reg != ST_IDLE);
      rd_data[1] = (state_reg == ST_SELF);
      rd_data[2] = sd_cke;
      rd_data[7:4] = last_hit_reg;
    end else if (cs_area) begin
      unique case (sub)
        ebc_pkg::SUB_SIZE_TYPE: rd_data[6:0] = {size_reg[cs_num], mode_reg[cs_num]};
        ebc_pkg::SUB_SRAM_WAIT: rd_data[2:0] = sram_wait_reg[cs_num];
        ebc_pkg::SUB_BASE: rd_data[15:4] = base_reg[cs_num];
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_go) begin
      wb_dat_o <= rd_data;
    end
  end

  // Delay counter load, one shared counter for every spacing
  always_comb begin
    cnt_load = 1'b0;
    cnt_value = 3'h0;
    unique case (state_reg)
      ST_IDLE: begin
        if (!sr_req && mem_req && !mem_ack && any_hit && !sel_sdram) begin
          cnt_load = 1'b1;
          cnt_value = sram_wait_reg[sel_cs];
        end else if (!sr_req && mem_req && !mem_ack && any_hit) begin
          cnt_load = 1'b1;
          cnt_value = rcd_cyc;
        end
      end
      ST_RCD: begin
        if (cnt_zero && mem_we) begin
          cnt_load = 1'b1;
          cnt_value = {1'b0, wr_cyc};
        end
      end
      ST_SELF: begin
        if (!sr_req) begin
          cnt_load = 1'b1;
          cnt_value = esr_cyc;
        end
      end
      default: begin
        cnt_load = 1'b0;
      end
    endcase
  end

  ebc_delay_cnt #(
    .W(3)
  ) i_ebc_delay_cnt (
    .clk(clk),
    .reset_n(reset_n),
    .load(cnt_load),
    .value(cnt_value),
    .zero(cnt_zero)
  );

  // Access sequencer; ack blocks the held request for one cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      cs_n <= 4'hf;
      sd_cmd <= ebc_pkg::EBC_CMD_NOP;
      sd_cke <= 1'b1;
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      last_hit_reg <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      sd_cmd <= ebc_pkg::EBC_CMD_NOP;
      unique case (state_reg)
        ST_IDLE: begin
          if (sr_req) begin
            sd_cmd <= ebc_pkg::EBC_CMD_SELF_REFRESH;
            sd_cke <= 1'b0;
            state_reg <= ST_SELF;
          end else if (mem_req && !mem_ack) begin
            if (!any_hit) begin
              mem_ack <= 1'b1;
              mem_err <= 1'b1;
              last_hit_reg <= 4'h0;
            end else begin
              cs_n <= ~(4'h1 << sel_cs);
              last_hit_reg <= 4'h1 << sel_cs;
              if (sel_sdram) begin
                sd_cmd <= ebc_pkg::EBC_CMD_ACTIVE;
                state_reg <= ST_RCD;
              end else begin
                state_reg <= ST_SRAM;
              end
            end
          end
        end
        ST_SRAM: begin
          if (cnt_zero) begin
            cs_n <= 4'hf;
            mem_ack <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_RCD: begin
          if (cnt_zero) begin
            sd_cmd <= mem_we ? ebc_pkg::EBC_CMD_WRITE : ebc_pkg::EBC_CMD_READ;
            if (mem_we) begin
              state_reg <= ST_WREC;
            end else begin
              cs_n <= 4'hf;
              mem_ack <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_WREC: begin
          if (cnt_zero) begin
            cs_n <= 4'hf;
            mem_ack <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_SELF: begin
          if (!sr_req) begin
            sd_cke <= 1'b1;
            state_reg <= ST_EXIT;
          end
        end
        ST_EXIT: begin
          if (cnt_zero) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* hdl/ebc_win_if.sv */
// Purpose: Carries one chip select window to its decoder
// Assumes: Same clock domain on both sides
// Notes: Decoder answer is combinational
`timescale 1ns/1ps
interface ebc_win_if;
  logic [4:0] size_code;
  logic [1:0] mode;
  logic [11:0] base;
  logic [23:0] addr;
  logic hit;
  modport owner (output size_code, output mode, output base, output addr, input hit);
  modport decoder (input size_code, input mode, input base, input addr, output hit);
endinterface

/* verification/ebc_mem_model.sv */
// Purpose: External memory side, command spacing seen by the chips
// Assumes: Commands last one cycle
// Notes: Holds no data; the block carries none
`timescale 1ns/1ps
module ebc_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Memory pins
  input wire logic [2:0] sd_cmd,
  input wire logic sd_cke,
  // Measured gaps in cycles
  output int act_gap,
  output int exit_gap
);
  int since_act;
  int since_cke;
  logic cke_q;
  always_ff @(posedge clk) begin
    // Idle level in reset, so no false rise after it
    cke_q <= reset_n ? sd_cke : 1'b1;
    since_act <= since_act + 1;
    since_cke <= since_cke + 1;
    if (sd_cke && !cke_q) begin
      since_cke <= 1;
    end
    if (sd_cmd == ebc_pkg::EBC_CMD_ACTIVE) begin
      since_act <= 1;
      exit_gap <= since_cke;
    end
    if (sd_cmd == ebc_pkg::EBC_CMD_READ || sd_cmd == ebc_pkg::EBC_CMD_WRITE) begin
      act_gap <= since_act;
    end
  end
endmodule

/* verification/ebc_top_monitor.sv */
// Purpose: Port checks for ebc_top
// Assumes: Timing register written in lane 0
// Notes: Row-col shadow follows acked writes
`timescale 1ns/1ps
module ebc_top_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Memory side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [3:0] cs_n,
  input wire logic [2:0] sd_cmd,
  input wire logic sd_cke
);
  logic [2:0] rcd;
  int act_cnt;
  logic rw;
  assign rw = sd_cmd == ebc_pkg::EBC_CMD_READ || sd_cmd == ebc_pkg::EBC_CMD_WRITE;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Shadow taken at the acked edge only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rcd <= 3'h0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
        && wb_adr_i == 8'h24) begin
      rcd <= wb_dat_i[2:0];
    end
  end
  always_ff @(posedge clk) begin
    if (sd_cmd == ebc_pkg::EBC_CMD_ACTIVE) begin
      act_cnt <= 1;
    end else begin
      act_cnt <= act_cnt + 1;
    end
  end
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not acked next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  one_select_a: assert property ($onehot0(~cs_n))
    else $error("two chip selects low");
  miss_quiet_a: assert property (mem_err |-> mem_ack && cs_n == 4'hf && $past(cs_n) == 4'hf)
    else $error("miss with a chip select low");
  sdram_fourth_a: assert property (sd_cmd != 3'h0 |-> cs_n[2:0] == 3'h7)
    else $error("SDRAM command beside a low-numbered select");
  row_col_gap_a: assert property (rw |-> act_cnt == int'(rcd) + 1)
    else $error("wrong ACTIVE to column spacing");
  read_ack_a: assert property (sd_cmd == ebc_pkg::EBC_CMD_READ |-> mem_ack)
    else $error("read not acked with READ");
  cke_entry_a: assert property ($fell(sd_cke) |-> sd_cmd == ebc_pkg::EBC_CMD_SELF_REFRESH)
    else $error("clock enable dropped without self-refresh");
  col_single_a: assert property (rw |=> sd_cmd == ebc_pkg::EBC_CMD_NOP)
    else $error("column command longer than one cycle");
  cover property (sd_cmd == ebc_pkg::EBC_CMD_ACTIVE);
  cover property (mem_err);
  cover property ($fell(sd_cke));
endmodule
bind ebc_top ebc_top_monitor i_ebc_top_monitor (.clk(clk), .reset_n(reset_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .mem_err(mem_err), .cs_n(cs_n), .sd_cmd(sd_cmd), .sd_cke(sd_cke));

/* verification/tb_ebc_top.sv */
// Purpose: Register, decode and timing tests for ebc_top
// Assumes: Inputs driven at rising edges
// Notes: Two idle cycles between memory accesses
`timescale 1ns/1ps
module tb_ebc_top;
  logic clk, reset_n, cyc, stb, we, mem_req, mem_we, mem_ack, mem_err, sd_cke, err, wb_ack;
  logic [7:0] adr, t;
  logic [3:0] sel, cs_n, cs;
  logic [31:0] dat, wb_q, q;
  logic [23:0] mem_addr, h, s;
  logic [2:0] sd_cmd;
  int fails, n_tests, lat, act_gap, exit_gap;
  ebc_top i_ebc_top (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_q),
    .wb_ack_o(wb_ack), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_err(mem_err), .cs_n(cs_n), .sd_cmd(sd_cmd), .sd_cke(sd_cke));
  ebc_mem_model i_ebc_mem_model (.clk(clk), .reset_n(reset_n), .sd_cmd(sd_cmd),
    .sd_cke(sd_cke), .act_gap(act_gap), .exit_gap(exit_gap));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (wb_ack !== 1'b1);
    q = wb_q;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Latency counts edges up to the one that sees ack
  task automatic mem(input logic w, input logic [23:0] a);
    lat = 0;
    cs = 4'hf;
    mem_req <= 1'b1;
    mem_we <= w;
    mem_addr <= a;
    do begin
      @(posedge clk);
      lat++;
      if (cs_n !== 4'hf) cs = cs_n;
    end while (mem_ack !== 1'b1);
    err = mem_err;
    mem_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Run takes well under 10k cycles
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {reset_n, cyc, stb, we, mem_req, mem_we} = 6'h0;
    {adr, sel, dat, mem_addr} = {8'h0, 4'h3, 32'h0, 24'h0};
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(8'h24, 32'h0); // reset value
    rd(8'h40, 32'h0); // reset value
    wb(1, 8'h24, 32'hff);
    rd(8'h24, 32'hff); // fields held
    wb(1, 8'h40, 32'hff);
    rd(8'h40, 32'h7c); // mode stored off
    wb(1, 8'h54, 32'hff);
    rd(8'h54, 32'h07); // reserved bits
    wb(1, 8'h58, 32'h123f);
    rd(8'h58, 32'h1230); // base field
    wb(1, 8'h28, 32'h5a);
    rd(8'h28, 32'h0);
    wb(1, 8'h54, 32'h0);
    // Code 16 shifts out to zero, so its hit address spans all lines
    for (int k = 0; k < 18; k++) begin
      s = 24'h000001 << (k + 8);
      h = (24'h123000 & ~(s - 24'h1)) | (s - 24'h1);
      wb(1, 8'h50, {k[4:0], 2'h1});
      mem(0, h);
      chk(err, k > 16); // full and reserved
      chk(cs, k > 16 ? 4'hf : 4'hd); // window hit
      if (k < 16) begin
        mem(0, h ^ s);
        chk(err, 1'b1); // compared line differs
      end
    end
    wb(1, 8'h50, {ebc_pkg::SIZE_FULL, 2'h0});
    mem(0, 24'h000000);
    chk(err, 1'b1); // disabled select
    for (int n = 0; n < 8; n++) begin
      wb(1, 8'h50, {ebc_pkg::SIZE_FULL, n[0] ? 2'h2 : 2'h1});
      wb(1, 8'h54, n);
      mem(n[1], 24'h000400);
      chk(lat, n + 3); // wait states
    end
    wb(1, 8'h50, 32'h0);
    wb(1, 8'h70, {ebc_pkg::SIZE_FULL, 2'h3});
    for (int i = 0; i < 2; i++) begin
      t = i ? 8'h55 : 8'hf8;
      wb(1, 8'h24, t);
      mem(0, 24'h000100);
      chk(lat, t[2:0] + 3); // read spacing
      chk(act_gap, t[2:0] + 1); // chip side gap
      chk(cs, 4'h7); // fourth select
      mem(1, 24'h000100);
      chk(lat, t[2:0] + t[7:6] + 4); // write recovery
      wb(1, 8'h74, 32'h4);
      @(negedge clk);
      chk(sd_cke, 1'b0); // self-refresh entry
      @(posedge clk);
      rd(8'h80, 32'h83); // status in self-refresh
      wb(1, 8'h74, 32'h0);
      mem(0, 24'h000200);
      chk(exit_gap >= t[5:3] + 1 && exit_gap <= t[5:3] + 3, 1'b1); // exit delay
    end
    tally_and_finish();
  end
endmodule
